// [logic/adc_result_formatting.sv]
// ADC result path: Avalon-MM registers, conversion sequencing, result formatting, interrupt
`default_nettype none
module adc_result_formatting
  import adc_result_pkg::*;
#(
  parameter int CONV_LEN = CONV_CYCLES
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [adc_result_pkg::ADDR_W-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  output logic [adc_result_pkg::RESULT_W-1:0] sample_value_unused_guard,
  input wire logic [adc_result_pkg::RESULT_W-1:0] sample_value,
  output logic [adc_result_pkg::CHAN_W-1:0] channel_select,
  output logic converter_on,
  output logic irq
);
  initial begin
    if (CONV_LEN < 1 || CONV_LEN > 255) $error("CONV_LEN must lie in 1..255");
  end

  typedef enum logic [1:0] {IDLE, CONVERT, LOAD} conv_state_t;

  typedef struct packed {
    conv_state_t state;
    logic [7:0] count;
    logic [7:0] control;
    logic [7:0] config_r;
    logic [7:0] res_high;
    logic [7:0] res_low;
    logic [7:0] irq_status;
    logic [7:0] irq_mask;
    logic [31:0] rdata;
    logic ack;
    logic wait_hi;
    logic [RESULT_W-1:0] echo;
    logic irq;
  } state_t;

  state_t s_q;
  state_t s_d;
  logic [7:0] packed_high;
  logic [7:0] packed_low;
  logic [7:0] wbyte;
  logic wr_hit;
  logic rd_hit;
  logic [7:0] done_set;

  // Formatting of the raw converter value
  adc_result_pack #(.RESULT_W(RESULT_W)) u_pack (
    .value(sample_value),
    .justify_right(s_q.config_r[CFG_JUSTIFY_BIT]),
    .high_byte(packed_high),
    .low_byte(packed_low)
  );

  // Address decode for word-aligned registers
  function automatic logic [1:0] reg_index(input logic [ADDR_W-1:0] a);
    reg_index = a[3:2];
  endfunction : reg_index

  // One-cycle wait before each answer keeps read data registered
  always_comb begin
    s_d = s_q;
    wbyte = writedata[7:0] & {8{byteenable[0]}};
    done_set = 8'h00;
    // Writes land only at the edge where waitrequest is seen low
    wr_hit = write && s_q.ack;
    rd_hit = read && !s_q.ack;
    s_d.ack = (read || write) && !s_q.ack;
    s_d.wait_hi = !s_d.ack;
    s_d.echo = sample_value;
    // Sequencer: busy bit set with enable set starts, busy stays high until load
    unique case (s_q.state)
      IDLE: begin
        if (s_q.control[CTL_BUSY_BIT] && s_q.control[CTL_ENABLE_BIT]) begin
          s_d.state = CONVERT;
          s_d.count = 8'(CONV_LEN - 1);
        end
      end
      CONVERT: begin
        if (s_q.count == 8'h00) begin
          s_d.state = LOAD;
        end else begin
          s_d.count = s_q.count - 8'h01;
        end
      end
      LOAD: begin
        s_d.res_high = packed_high;
        s_d.res_low = packed_low;
        s_d.control[CTL_BUSY_BIT] = 1'b0;
        s_d.irq_status[IRQ_DONE_BIT] = 1'b1;
        done_set[IRQ_DONE_BIT] = 1'b1;
        s_d.state = IDLE;
      end
      default: begin
        s_d.state = IDLE;
      end
    endcase
    // Register writes; the sticky set takes priority over a clear
    if (wr_hit && byteenable[0]) begin
      if (!address[PAGE_BIT]) begin
        unique case (reg_index(address))
          2'd0: begin
            // Busy only settable while idle, never cleared by software mid-conversion
            s_d.control = {1'b0, wbyte[6:2], s_d.control[CTL_BUSY_BIT] |
              (wbyte[CTL_BUSY_BIT] & (s_q.state == IDLE)), wbyte[CTL_ENABLE_BIT]};
            if (s_q.state == IDLE && !wbyte[CTL_BUSY_BIT]) begin
              s_d.control[CTL_BUSY_BIT] = 1'b0;
            end
          end
          2'd1: s_d.config_r = wbyte & CFG_WRITE_MASK;
          2'd2: if (s_q.state != LOAD) s_d.res_high = wbyte;
          2'd3: if (s_q.state != LOAD) s_d.res_low = wbyte;
        endcase
      end else if (reg_index(address) == 2'd0) begin
        // Write one to clear; a done event in the same cycle wins
        s_d.irq_status = (s_q.irq_status & ~wbyte) | done_set;
      end else if (reg_index(address) == 2'd1) begin
        s_d.irq_mask = wbyte;
      end
    end
    // Read mux; unmapped words read zero
    s_d.rdata = 32'h0000_0000;
    if (rd_hit) begin
      if (!address[PAGE_BIT]) begin
        unique case (reg_index(address))
          2'd0: s_d.rdata = {24'h000000, s_q.control};
          2'd1: s_d.rdata = {24'h000000, s_q.config_r};
          2'd2: s_d.rdata = {24'h000000, s_q.res_high};
          2'd3: s_d.rdata = {24'h000000, s_q.res_low};
        endcase
      end else if (reg_index(address) == 2'd0) begin
        s_d.rdata = {24'h000000, s_q.irq_status};
      end else if (reg_index(address) == 2'd1) begin
        s_d.rdata = {24'h000000, s_q.irq_mask};
      end
    end
    s_d.irq = |(s_d.irq_status & s_d.irq_mask);
  end

  // Result bytes are not reset: kept across reset as the real part does
  always_ff @(posedge clk) begin
    if (rst) begin
      s_q.state <= IDLE;
      s_q.count <= 8'h00;
      s_q.control <= CONTROL_RST;
      s_q.config_r <= CONFIG_RST;
      s_q.irq_status <= 8'h00;
      s_q.irq_mask <= IRQ_MASK_RST;
      s_q.rdata <= 32'h0000_0000;
      s_q.ack <= 1'b0;
      s_q.wait_hi <= 1'b1;
      s_q.echo <= {RESULT_W{1'b0}};
      s_q.irq <= 1'b0;
      s_q.res_high <= s_q.res_high;
      s_q.res_low <= s_q.res_low;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs straight from flip-flops
  assign readdata = s_q.rdata;
  assign waitrequest = s_q.wait_hi;
  assign channel_select = s_q.control[CTL_CHAN_LSB +: CHAN_W];
  assign converter_on = s_q.control[CTL_ENABLE_BIT];
  assign irq = s_q.irq;
  assign sample_value_unused_guard = s_q.echo;
endmodule : adc_result_formatting
`default_nettype wire

// [logic/adc_result_pack.sv]
// Packs a finished conversion value into high and low result bytes
`default_nettype none
module adc_result_pack #(
  parameter int RESULT_W = 10
) (
  input wire logic [RESULT_W-1:0] value,
  input wire logic justify_right,
  output logic [7:0] high_byte,
  output logic [7:0] low_byte
);
  initial begin
    if (RESULT_W != 10) $error("adc_result_pack: only a 10-bit result is supported");
  end

  // Unused bits forced to zero in either format
  always_comb begin
    if (justify_right) begin
      high_byte = {6'h00, value[9:8]};
      low_byte = value[7:0];
    end else begin
      high_byte = value[9:2];
      low_byte = {value[1:0], 6'h00};
    end
  end
endmodule : adc_result_pack
`default_nettype wire

// [logic/adc_result_pkg.sv]
// Package of register offsets, field positions and reset values for the ADC result block
`default_nettype none
package adc_result_pkg;
  // Register byte addresses (word aligned on the Avalon bus)
  localparam logic [3:0] OFF_CONTROL = 4'h0;
  localparam logic [3:0] OFF_CONFIG = 4'h4;
  localparam logic [3:0] OFF_RES_HIGH = 4'h8;
  localparam logic [3:0] OFF_RES_LOW = 4'hC;
  localparam logic [3:0] OFF_IRQ_STATUS = 4'h0;
  localparam logic [3:0] OFF_IRQ_MASK = 4'h4;
  // Address bit that selects the interrupt page
  localparam int ADDR_W = 5;
  localparam int PAGE_BIT = 4;
  // Control register fields
  localparam int CTL_ENABLE_BIT = 0;
  localparam int CTL_BUSY_BIT = 1;
  localparam int CTL_CHAN_LSB = 2;
  localparam int CHAN_W = 5;
  // Config register fields
  localparam int CFG_JUSTIFY_BIT = 7;
  localparam logic [7:0] CFG_WRITE_MASK = 8'hF7;
  // Reset values
  localparam logic [7:0] CONTROL_RST = 8'h00;
  localparam logic [7:0] CONFIG_RST = 8'h00;
  localparam logic [7:0] IRQ_MASK_RST = 8'h00;
  // Interrupt status bit for conversion done
  localparam int IRQ_DONE_BIT = 0;
  // Conversion time in cycles of the device clock
  localparam int CONV_CYCLES = 12;
  localparam int RESULT_W = 10;
endpackage : adc_result_pkg
`default_nettype wire

// [test/adc_result_monitor.sv]
// Checker of bus timing and control side effects for the ADC result block
`default_nettype none
module adc_result_monitor
  import adc_result_pkg::*;
#(
  parameter int CONV_LEN = CONV_CYCLES
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [adc_result_pkg::ADDR_W-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  input wire logic [31:0] readdata,
  input wire logic waitrequest,
  input wire logic [adc_result_pkg::CHAN_W-1:0] channel_select,
  input wire logic converter_on,
  input wire logic irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  logic wr_ctl;
  logic rd_ok;
  // Taken transfers only; a lane-0 mask blocks the write
  assign wr_ctl = write && !waitrequest && address == 5'h00 && byteenable[0];
  assign rd_ok = read && !waitrequest;
  a_wait_answer: assert property ((read || write) && waitrequest |=> !waitrequest)
    else $error("request not answered in the second cycle");
  a_answer_once: assert property ((read || write) && !waitrequest |=> waitrequest)
    else $error("answer stood longer than one cycle");
  a_chan_write: assert property (!$stable(channel_select) |->
    $past(wr_ctl) && channel_select == $past(writedata[6:2])) else $error("channel moved alone");
  a_enable_write: assert property (!$stable(converter_on) |->
    $past(wr_ctl) && converter_on == $past(writedata[0])) else $error("enable moved alone");
  a_reset_clear: assert property (disable iff (1'b0) rst |=> !irq && !converter_on)
    else $error("reset left control or irq set");
  a_upper_zero: assert property (rd_ok |-> readdata[31:8] == 24'h0)
    else $error("upper read lanes not zero");
  a_unmapped_zero: assert property (rd_ok && address == 5'h18 |-> readdata == 32'h0)
    else $error("unmapped read not zero");
  a_ctl_readback: assert property (rd_ok && address == 5'h00 |-> !readdata[7] &&
    readdata[6:2] == channel_select && readdata[0] == converter_on) else $error("control read");
  a_cfg_gap: assert property (rd_ok && address == 5'h04 |-> !readdata[3])
    else $error("config bit 3 not zero");
endmodule : adc_result_monitor
bind adc_result_formatting adc_result_monitor #(.CONV_LEN(CONV_LEN)) mon (.clk(clk), .rst(rst),
  .address(address), .read(read), .write(write), .writedata(writedata), .byteenable(byteenable),
  .readdata(readdata), .waitrequest(waitrequest), .channel_select(channel_select),
  .converter_on(converter_on), .irq(irq));
`default_nettype wire

// [test/tb_top.sv]
// Register-level testbench of the ADC result block
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import adc_result_pkg::*;
  logic clk = 0, rst = 1, read = 0, write = 0, waitrequest, converter_on, irq;
  logic [4:0] address = '0, channel_select;
  logic [31:0] writedata = '0, readdata;
  logic [9:0] sample_value = '0, guard;
  logic [3:0] byteenable = 4'hF;
  logic [7:0] q;
  int fails = 0, n_tests = 0;
  always #4 clk = ~clk;
  adc_result_formatting DUT (.clk(clk), .rst(rst), .address(address), .read(read),
    .write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .sample_value_unused_guard(guard), .sample_value(sample_value),
    .channel_select(channel_select), .converter_on(converter_on), .irq(irq));
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : give_verdict
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) fails++;
    if (seen !== exp) $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
  endtask : chk
  // Holds the request until waitrequest is seen low, then releases it
  task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] d);
    int k;
    k = 0;
    address <= a;
    write <= w;
    read <= !w;
    writedata <= {24'h0, d};
    do begin
      @(posedge clk);
      k++;
    end while (waitrequest !== 1'b0 && k < 20);
    if (k >= 20) fails++;
    if (k >= 20) give_verdict();
    q = readdata[7:0];
    read <= 1'b0;
    write <= 1'b0;
    @(posedge clk);
  endtask : bus
  task automatic rd(input logic [4:0] a, input logic [7:0] exp);
    bus(1'b0, a, 8'h00);
    chk(q, exp);
  endtask : rd
  initial begin
    int k;
    logic [9:0] v;
    logic j;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd(5'h04, CONFIG_RST);
    rd(5'h18, 8'h00);
    bus(1'b1, 5'h08, 8'hA5);
    bus(1'b1, 5'h0C, 8'h5A);
    // Soft reset must leave the result pair alone
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd(5'h08, 8'hA5);
    rd(5'h0C, 8'h5A);
    rd(5'h14, IRQ_MASK_RST);
    // Lane 0 masked: the write must be ignored
    byteenable <= 4'h0;
    bus(1'b1, 5'h08, 8'hFF);
    byteenable <= 4'hF;
    rd(5'h08, 8'hA5);
    bus(1'b1, 5'h14, 8'h01);
    // Left, right, then right with the interrupt masked
    for (int i = 0; i < 3; i++) begin
      j = (i != 0);
      v = (i == 0) ? 10'h2C7 : 10'h135;
      sample_value <= v;
      if (i == 2) bus(1'b1, 5'h14, 8'h00);
      bus(1'b1, 5'h04, {j, 7'h00});
      bus(1'b1, 5'h00, 8'h0D);
      repeat (20) @(posedge clk);
      bus(1'b1, 5'h00, 8'h0F);
      rd(5'h00, 8'h0F);
      k = 0;
      do begin
        bus(1'b0, 5'h00, 8'h00);
        k++;
      end while (q[1] !== 1'b0 && k < 50);
      chk(q, 8'h0D);
      chk({7'h0, irq}, {7'h0, i < 2});
      rd(5'h10, 8'h01);
      rd(5'h08, j ? {6'h00, v[9:8]} : v[9:2]);
      rd(5'h0C, j ? v[7:0] : {v[1:0], 6'h00});
      chk(guard[7:0], v[7:0]);
      bus(1'b1, 5'h10, 8'h01);
      repeat (2) @(posedge clk);
      chk({7'h0, irq}, 8'h00);
    end
    give_verdict();
  end
endmodule : tb_top
`default_nettype wire
